/* File: design/stepper_host.sv */
// Contract
// - Power-up reset initialises all sequencing state
// - Controller holds enable low below supply
// - Controller waits 10 us after reset release
// - Step clock up to 50 kHz, 10 us pulses
// - Edge select high: rising only, else both
// - Direction input picks rotation sense
// - Direction stable 6.25 us around rising edge
// - Enable low forces all phases off
// - Enable return resumes same sequence point
// - Controller slows clock gradually before stopping; code doubles the period once, for the last 4 steps
// - Excitation select: low full, high half
// - Mode inputs stable 5 us around edge; code changes them at the falling edge, which is active when both edges step
// - Trips latch and force phases off
// - Latch cleared only by resets
// - Overcurrent trips above current threshold
// - Blank overcurrent 5.5 us after chop start
// - Overheat trips like overcurrent
// - Reset low clears; release loads first+fourth
// - Fault output low while latch set
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "stepper_cfg.svh"
module stepper_host (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output var  logic        awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output var  logic        wready,
    output var  logic [1:0]  bresp,
    output var  logic        bvalid,
    input  wire logic        bready,
    // AXI4-Lite read
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output var  logic        arready,
    output var  logic [31:0] rdata,
    output var  logic [1:0]  rresp,
    output var  logic        rvalid,
    input  wire logic        rready,
    // Supply monitor
    input  wire logic        supply_ok,
    // Link to the driver
    step_link_if.host        link
);
    import stepper_pkg::*;

    // ===================================================
    // Synchronise fault and supply
    logic [1:0] in_s;

    pin_sync #(
        .WIDTH(2)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       ({link.fault_n, supply_ok}),
        .q       (in_s)
    );

    // ===================================================
    // Register decode, shared by reads and writes
    function automatic logic mapped(input logic [7:0] a);
        return (a == `OFS_CTRL) || (a == `OFS_STEPS)
               || (a == `OFS_HALF) || (a == `OFS_STATUS);
    endfunction

    function automatic logic [31:0] read_word(
        input host_state_t s,
        input logic [7:0]  a,
        input logic [1:0]  pins
    );
        logic [31:0] v;
        v = 32'h0;
        if (a == `OFS_CTRL)
            v[3:0] = s.ctrl;
        else if (a == `OFS_STEPS)
            v[15:0] = s.steps;
        else if (a == `OFS_HALF)
            v[15:0] = s.half;
        else if (a == `OFS_STATUS)
        begin
            v[`STAT_BUSY]   = (s.mode != H_IDLE);
            v[`STAT_FAULT]  = !pins[1];
            v[`STAT_SUPPLY] = pins[0];
        end
        return v;
    endfunction

    host_state_t r;
    host_state_t n;
    logic [16:0] half_eff;
    logic [31:0] wv;

    // Next-state logic
    always_comb
    begin
        n = r;
        wv = 32'h0;
        // Doubled period over the last steps eases the stop
        half_eff = (r.steps <= 16'(`RAMP_STEPS))
                   ? {r.half, 1'b0} : {1'b0, r.half};
        // Enable follows supply at once
        n.en = r.ctrl[`CTRL_EN] && in_s[0];
        if (r.timer != 17'h0)
            n.timer = r.timer - 17'h1;

        // Step sequencer
        unique case (r.mode)
            H_IDLE:
            begin
                // Mode pins move only far from any rising edge
                n.exc      = r.ctrl[`CTRL_EXC];
                n.edge_sel = r.ctrl[`CTRL_EDGE];
                n.dir      = r.ctrl[`CTRL_DIR];
                if (r.steps != 16'h0)
                begin
                    n.mode  = H_RUN;
                    n.timer = half_eff - 17'h1;
                end
            end
            H_RUN:
            begin
                if (r.timer == 17'h0)
                begin
                    if (r.steps == 16'h0 && !(r.step_clock && r.edge_sel))
                        n.mode = H_IDLE;
                    else
                    begin
                        n.step_clock = !r.step_clock;
                        n.timer      = half_eff - 17'h1;
                        if (!r.step_clock || !r.edge_sel)
                            n.steps = r.steps - 16'h1;
                        if (r.step_clock)
                        begin
                            n.exc      = r.ctrl[`CTRL_EXC];
                            n.edge_sel = r.ctrl[`CTRL_EDGE];
                            n.dir      = r.ctrl[`CTRL_DIR];
                        end
                    end
                end
            end
            H_RST_LOW:
            begin
                n.step_clock = 1'b0;
                n.rst_n      = 1'b0;
                if (r.timer == 17'h0)
                begin
                    n.rst_n = 1'b1;
                    n.mode  = H_RST_GAP;
                    n.timer = 17'(`RESET_GAP_CYC) - 17'h1;
                end
            end
            H_RST_GAP:
            begin
                if (r.timer == 17'h0)
                    n.mode = H_IDLE;
            end
        endcase

        // Write channels taken in either order
        if (awvalid && r.awready)
        begin
            n.got_aw = 1'b1;
            n.waddr  = awaddr;
        end
        if (wvalid && r.wready)
        begin
            n.got_w = 1'b1;
            n.wdata = wdata;
            n.wstrb = wstrb;
        end
        if (r.got_aw && r.got_w && !r.bvalid)
        begin
            n.got_aw = 1'b0;
            n.got_w  = 1'b0;
            n.bvalid = 1'b1;
            n.bresp  = mapped(r.waddr) ? `RESP_OKAY : `RESP_SLVERR;
            wv = read_word(r, r.waddr, in_s);
            for (int i = 0; i < 4; i++)
                if (r.wstrb[i])
                    wv[8*i +: 8] = r.wdata[8*i +: 8];
            if (r.waddr == `OFS_CTRL)
            begin
                n.ctrl = wv[3:0];
                if (r.wstrb[0] && r.wdata[`CTRL_RST])
                begin
                    n.mode  = H_RST_LOW;
                    n.steps = 16'h0;
                    n.timer = 17'(`RESET_LOW_CYC) - 17'h1;
                end
            end
            else if (r.waddr == `OFS_STEPS)
                n.steps = wv[15:0];
            else if (r.waddr == `OFS_HALF)
                n.half = (wv[15:0] < 16'(`PULSE_MIN_CYC))
                         ? 16'(`PULSE_MIN_CYC) : wv[15:0];
        end
        if (r.bvalid && bready)
            n.bvalid = 1'b0;
        n.awready = !n.got_aw && !n.bvalid;
        n.wready  = !n.got_w && !n.bvalid;

        // Read channel
        if (arvalid && r.arready)
        begin
            n.rvalid = 1'b1;
            n.rdata  = read_word(r, araddr, in_s);
            n.rresp  = mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (r.rvalid && rready)
            n.rvalid = 1'b0;
        n.arready = !n.rvalid;
    end

    // Register the state; reset runs a reset pulse on the pin
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            r       <= '0;
            r.mode  <= H_RST_LOW;
            r.timer <= 17'(`RESET_LOW_CYC);
            r.ctrl  <= `CTRL_RST_VAL;
            r.half  <= `HALF_RST_VAL;
        end
        else
        begin
            r <= n;
        end
    end

    // ===================================================
    // Outputs straight from the state register
    assign awready                = r.awready;
    assign wready                 = r.wready;
    assign bvalid                 = r.bvalid;
    assign bresp                  = r.bresp;
    assign arready                = r.arready;
    assign rvalid                 = r.rvalid;
    assign rdata                  = r.rdata;
    assign rresp                  = r.rresp;
    assign link.step_clock        = r.step_clock;
    assign link.excitation_select = r.exc;
    assign link.edge_select       = r.edge_sel;
    assign link.direction_select  = r.dir;
    assign link.sync_reset_n      = r.rst_n;
    assign link.enable            = r.en;
endmodule
`default_nettype wire

/* File: design/stepper_cfg.svh */
`ifndef STEPPER_CFG_SVH
`define STEPPER_CFG_SVH
// ===================================================
// Timing
`define CLK_PERIOD_NS   10
`define BLANK_NS        5500
`define BLANK_CYC       (`BLANK_NS / `CLK_PERIOD_NS)
`define PULSE_MIN_NS    10000
`define PULSE_MIN_CYC   ((`PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_GAP_NS    10000
`define RESET_GAP_CYC   ((`RESET_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_LOW_CYC   100
`define RAMP_STEPS      4
// ===================================================
// Register offsets
`define OFS_CTRL        8'h00
`define OFS_STEPS       8'h04
`define OFS_HALF        8'h08
`define OFS_STATUS      8'h0c
// ===================================================
// Field positions
`define CTRL_EN         0
`define CTRL_EXC        1
`define CTRL_EDGE       2
`define CTRL_DIR        3
`define CTRL_RST        4
`define STAT_BUSY       0
`define STAT_FAULT      1
`define STAT_SUPPLY     2
// ===================================================
// Reset values and answers
`define CTRL_RST_VAL    4'h4
`define HALF_RST_VAL    16'h03e8
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

/* File: design/stepper_pkg.sv */
`default_nettype none
package stepper_pkg;
    // ===================================================
    // Device state
    typedef struct packed {
        logic [2:0] pos;
        logic       clk_prev;
        logic       chop_prev;
        logic       trip;
        logic [9:0] blank_cnt;
        logic [3:0] phase;
        logic       fault_n;
    } dev_state_t;

    // ===================================================
    // Controller state
    typedef enum logic [1:0] {H_IDLE, H_RUN, H_RST_LOW, H_RST_GAP} host_mode_t;

    typedef struct packed {
        host_mode_t  mode;
        logic [3:0]  ctrl;
        logic [15:0] steps;
        logic [15:0] half;
        logic [16:0] timer;
        logic        step_clock;
        logic        exc;
        logic        edge_sel;
        logic        dir;
        logic        en;
        logic        rst_n;
        logic        got_aw;
        logic        got_w;
        logic [7:0]  waddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } host_state_t;
endpackage
`default_nettype wire

/* File: design/step_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
// ===================================================
// Pins between controller and driver logic
interface step_link_if;
    logic step_clock;
    logic excitation_select;
    logic edge_select;
    logic direction_select;
    logic sync_reset_n;
    logic enable;
    logic winding_first;
    logic winding_first_rev;
    logic winding_second;
    logic winding_second_rev;
    logic fault_n;

    modport host (
        output step_clock, excitation_select, edge_select,
        output direction_select, sync_reset_n, enable,
        input  winding_first, winding_first_rev, winding_second,
        input  winding_second_rev, fault_n
    );
    modport device (
        input  step_clock, excitation_select, edge_select,
        input  direction_select, sync_reset_n, enable,
        output winding_first, winding_first_rev, winding_second,
        output winding_second_rev, fault_n
    );
endinterface
`default_nettype wire

/* File: design/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// ===================================================
// Two-stage synchroniser for asynchronous pins
module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // Pins and synchronised copies
    input  wire logic [WIDTH-1:0] d,
    output var  logic [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } sync_state_t;

    sync_state_t r;
    sync_state_t n;

    // First stage feeds only the second
    always_comb
    begin
        n.s1 = d;
        n.s2 = r.s1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            r <= '0;
        else
            r <= n;
    end

    assign q = r.s2;
endmodule
`default_nettype wire

/* File: design/stepper_device.sv */
`timescale 1ns/1ps
`default_nettype none
`include "stepper_cfg.svh"
module stepper_device (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Link to the controller
    step_link_if.device link,
    // Analog front end levels
    input  wire logic supply_ok,
    input  wire logic overcurrent_cmp,
    input  wire logic overtemp_hot,
    input  wire logic chop_on
);
    import stepper_pkg::*;

    // ===================================================
    // Pin synchronisers
    logic [9:0] pin_s;
    logic       clk_s;
    logic       exc_s;
    logic       edge_s;
    logic       dir_s;
    logic       rst_s;
    logic       en_s;
    logic       sup_s;
    logic       oc_s;
    logic       hot_s;
    logic       chop_s;

    pin_sync #(
        .WIDTH(10)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       ({link.step_clock, link.excitation_select,
                   link.edge_select, link.direction_select,
                   link.sync_reset_n, link.enable, supply_ok,
                   overcurrent_cmp, overtemp_hot, chop_on}),
        .q       (pin_s)
    );

    // Unpack synchronised pins
    assign clk_s  = pin_s[9];
    assign exc_s  = pin_s[8];
    assign edge_s = pin_s[7];
    assign dir_s  = pin_s[6];
    assign rst_s  = pin_s[5];
    assign en_s   = pin_s[4];
    assign sup_s  = pin_s[3];
    assign oc_s   = pin_s[2];
    assign hot_s  = pin_s[1];
    assign chop_s = pin_s[0];

    // ===================================================
    // Sequence tables
    // Half-step table over {first, first_rev, second, second_rev};
    // even positions are the two-phase states
    function automatic logic [3:0] phase_of(input logic [2:0] p);
        logic [3:0] v;
        v = 4'h0;
        unique case (p)
            3'h0: v = 4'h9;
            3'h1: v = 4'h8;
            3'h2: v = 4'ha;
            3'h3: v = 4'h2;
            3'h4: v = 4'h6;
            3'h5: v = 4'h4;
            3'h6: v = 4'h5;
            3'h7: v = 4'h1;
        endcase
        return v;
    endfunction

    // Full step from an odd half-step point lands on the nearest
    // two-phase state, so a mode switch never loses phase
    function automatic logic [2:0] next_pos(
        input logic [2:0] p,
        input logic       half,
        input logic       rev
    );
        logic [2:0] d;
        d = (half || p[0]) ? 3'h1 : 3'h2;
        return rev ? p - d : p + d;
    endfunction

    // ===================================================
    // State
    dev_state_t r;
    dev_state_t n;
    logic       active;
    logic       chop_rise;
    logic       oc_hit;
    logic       in_reset;

    // Next-state logic
    always_comb
    begin
        n = r;
        n.clk_prev  = clk_s;
        n.chop_prev = chop_s;

        // Active edge decode
        active = (clk_s != r.clk_prev)
                 && (clk_s || !edge_s);

        // Power-up and pin reset
        in_reset = !sup_s || !rst_s;

        // Blanking window restarts at each chop on-period
        chop_rise = chop_s && !r.chop_prev;
        if (chop_rise)
            n.blank_cnt = 10'(`BLANK_CYC);
        else if (r.blank_cnt != 10'h000)
            n.blank_cnt = r.blank_cnt - 10'h001;

        // Comparator is trusted only outside blanking
        oc_hit = oc_s && chop_s && !chop_rise
                 && (r.blank_cnt == 10'h000);

        // Trip latch: a trip in a reset cycle still sets it
        n.trip = oc_hit || hot_s
                 || (r.trip && !in_reset);

        // Sequencer position
        if (in_reset)
            n.pos = 3'h0;
        else if (active && en_s)
            n.pos = next_pos(r.pos, exc_s, dir_s);
        else
            n.pos = r.pos;

        // Output gating; position survives enable low
        if (in_reset || !en_s || n.trip)
            n.phase = 4'h0;
        else
            n.phase = phase_of(n.pos);

        n.fault_n = !n.trip;
    end

    // Register the state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            r         <= '0;
            r.fault_n <= 1'b1;
        end
        else
        begin
            r <= n;
        end
    end

    // ===================================================
    // Outputs straight from the state register
    assign link.winding_first      = r.phase[3];
    assign link.winding_first_rev  = r.phase[2];
    assign link.winding_second     = r.phase[1];
    assign link.winding_second_rev = r.phase[0];
    assign link.fault_n            = r.fault_n;
endmodule
`default_nettype wire

/* File: bench/stepper_link_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ===================================================
// Watches the link between the two ends
module stepper_link_monitor (
    // Clock, reset and supply
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic supply_ok,
    // Link pins
    input wire logic step_clock,
    input wire logic edge_select,
    input wire logic sync_reset_n,
    input wire logic enable,
    input wire logic winding_first,
    input wire logic winding_first_rev,
    input wire logic winding_second,
    input wire logic winding_second_rev,
    input wire logic fault_n
);
    logic [3:0]  w;
    logic        clk_prev;
    logic [15:0] quiet;

    // Windings as one nibble, first phase on top
    assign w = {winding_first, winding_first_rev, winding_second,
                winding_second_rev};

    // Cycles since last toggle or pin reset; saturates so never wraps
    always_ff @(posedge aclk)
    begin
        clk_prev <= step_clock;
        if (!aresetn || !sync_reset_n || step_clock != clk_prev)
            quiet <= 16'h0;
        else if (quiet != 16'hffff)
            quiet <= quiet + 16'h1;
    end

    // ===================================================
    // Properties
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    toggle_gap_a:
        assert property (step_clock != clk_prev |-> quiet >= 16'h03e7)
        else $error("step clock toggled too soon");
    disabled_off_a:
        assert property ((!enable)[*3] |=> w == 4'h0)
        else $error("windings driven while disabled");
    tripped_off_a:
        assert property (!fault_n |-> w == 4'h0)
        else $error("windings driven while tripped");
    trip_latch_a:
        assert property ((!fault_n && sync_reset_n && supply_ok)[*3]
                         |=> !fault_n)
        else $error("trip cleared without reset");
    hold_still_a:
        assert property ($stable({step_clock, sync_reset_n, enable,
                                  supply_ok})[*4] |=> $stable(w) || !fault_n)
        else $error("windings moved without an edge");
    edge_moves_a:
        assert property (($rose(step_clock)
            || $fell(step_clock) && !edge_select) && enable && fault_n
            && sync_reset_n && supply_ok |-> ##3 w != $past(w, 3))
        else $error("active edge did not step");
    fall_ignored_a:
        assert property ($fell(step_clock) && edge_select && sync_reset_n
                         |-> ##3 w == $past(w, 3))
        else $error("falling edge stepped in rising-only mode");
    reset_load_a:
        assert property ($rose(sync_reset_n) && enable && fault_n
                         && supply_ok |-> ##3 w == 4'h9)
        else $error("pin reset did not load first state");
endmodule
`default_nettype wire

/* File: bench/tb_stepper_phase_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "stepper_cfg.svh"
module tb_stepper_phase_sequencer;
    // ===================================================
    // Signals, all inputs valued at time zero
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h0;
    logic        awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'hf;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic [7:0]  araddr = 8'h0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        supply_ok = 1'b1;
    logic        overcurrent_cmp = 1'b0;
    logic        overtemp_hot = 1'b0;
    logic        chop_on = 1'b0;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic        arready;
    logic        rvalid;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [3:0]  windings;
    int          err_count = 0;
    int          samples_checked = 0;

    // ===================================================
    // The two ends, joined by the link
    step_link_if link ();
    stepper_host stepper_host_i (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .supply_ok, .link
    );
    stepper_device stepper_device_i (
        .aclk, .aresetn, .link, .supply_ok, .overcurrent_cmp,
        .overtemp_hot, .chop_on
    );
    stepper_link_monitor stepper_link_monitor_i (
        .aclk, .aresetn, .supply_ok,
        .step_clock(link.step_clock), .edge_select(link.edge_select),
        .sync_reset_n(link.sync_reset_n), .enable(link.enable),
        .winding_first(link.winding_first),
        .winding_first_rev(link.winding_first_rev),
        .winding_second(link.winding_second),
        .winding_second_rev(link.winding_second_rev),
        .fault_n(link.fault_n)
    );
    // Windings as one nibble, first phase on top
    assign windings = {link.winding_first, link.winding_first_rev,
                       link.winding_second, link.winding_second_rev};

    // Free-running 100 MHz clock
    always #5 aclk = ~aclk;

    // ===================================================
    // Verdict and bookkeeping
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic compare(input logic [31:0] got, input logic [31:0] exp,
                           input string what);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: %s got %0h", $time, what, got);
        end
    endtask

    // A wait that ran out ends the run at once
    task automatic stuck(input string what);
        err_count++;
        $display("unexpected at %0t: no answer to %s", $time, what);
        complete_run();
    endtask

    // ===================================================
    // Register bus cycles; valid held until its ready is sampled
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             output logic [1:0] resp);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if (bvalid)
                break;
        end
        if (n == 50)
            stuck("write");
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                            output logic [1:0] resp);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
        if (n == 50)
            stuck("read");
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic put(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_write(a, d, r);
        compare(32'(r), 32'(`RESP_OKAY), "write answer");
    endtask
    // Polls busy; the extra cycles cover the pin synchronisers
    task automatic wait_idle();
        logic [31:0] d;
        logic [1:0]  r;
        int          n;
        repeat (4) @(posedge aclk);
        for (n = 0; n < 4000; n++)
        begin
            axi_read(`OFS_STATUS, d, r);
            if (d[`STAT_BUSY] === 1'b0)
                break;
        end
        if (n == 4000)
            stuck("busy poll");
        repeat (4) @(posedge aclk);
    endtask

    task automatic run_to(input logic [3:0] ctrl, input logic [15:0] n,
                          input logic [3:0] exp, input string what);
        put(`OFS_CTRL, {28'h0, ctrl});
        put(`OFS_STEPS, {16'h0, n});
        wait_idle();
        compare(32'(windings), 32'(exp), what);
    endtask
    // ===================================================
    // Scenarios
    task automatic bus_and_start();
        logic [31:0] d;
        logic [1:0]  r;
        axi_read(`OFS_HALF, d, r);
        compare(d, 32'h3e8, "half period after reset");
        axi_read(8'h10, d, r);
        compare(32'(r), 32'(`RESP_SLVERR), "unmapped read answer");
        compare(d, 32'h0, "unmapped read data");
        axi_write(8'h14, 32'h1, r);
        compare(32'(r), 32'(`RESP_SLVERR), "unmapped write answer");
        put(`OFS_CTRL, 32'h11);
        wait_idle();
        compare(32'(windings), 32'h9, "first state");
    endtask

    // Odd position reached in half mode, then a full step from it
    task automatic mode_runs();
        run_to(4'h1, 16'h2, 4'h6, "both edges forward");
        run_to(4'h5, 16'h2, 4'h9, "rising only");
        run_to(4'hb, 16'h3, 4'h4, "half reverse");
        run_to(4'h1, 16'h1, 4'h5, "full from odd");
    endtask

    task automatic enable_gate();
        put(`OFS_CTRL, 32'h0);
        repeat (5) @(posedge aclk);
        compare(32'(windings), 32'h0, "disabled windings");
        put(`OFS_STEPS, 32'h1);
        wait_idle();
        put(`OFS_CTRL, 32'h1);
        repeat (5) @(posedge aclk);
        compare(32'(windings), 32'h5, "resumed windings");
    endtask

    task automatic heat_trip();
        logic [31:0] d;
        logic [1:0]  r;
        overtemp_hot <= 1'b1;
        repeat (3) @(posedge aclk);
        overtemp_hot <= 1'b0;
        repeat (100) @(posedge aclk);
        compare(32'(windings), 32'h0, "tripped windings");
        compare(32'(link.fault_n), 32'h0, "fault flag");
        axi_read(`OFS_STATUS, d, r);
        compare(32'(d[`STAT_FAULT]), 32'h1, "fault status");
        put(`OFS_CTRL, 32'h11);
        wait_idle();
        compare(32'(link.fault_n), 32'h1, "fault after pin reset");
        compare(32'(windings), 32'h9, "state after pin reset");
    endtask

    // Comparator high from the chop start: blanked first, then trips
    task automatic current_trip();
        chop_on <= 1'b1;
        overcurrent_cmp <= 1'b1;
        repeat (500) @(posedge aclk);
        compare(32'(link.fault_n), 32'h1, "fault in blanking");
        repeat (100) @(posedge aclk);
        compare(32'(link.fault_n), 32'h0, "overcurrent fault");
        chop_on <= 1'b0;
        overcurrent_cmp <= 1'b0;
        repeat (5) @(posedge aclk);
        supply_ok <= 1'b0;
        repeat (10) @(posedge aclk);
        compare(32'(link.enable), 32'h0, "enable at low supply");
        supply_ok <= 1'b1;
        repeat (10) @(posedge aclk);
        compare(32'(link.fault_n), 32'h1, "fault after power-up");
    endtask

    // ===================================================
    // Main sequence
    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        wait_idle();
        bus_and_start();
        mode_runs();
        enable_gate();
        heat_trip();
        current_trip();
        complete_run();
    end
endmodule
`default_nettype wire
